// file: inc/btlx_pkg.sv
package btlx_pkg;

	// Register byte offsets
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_SRC    = 8'h04;
	localparam logic [7:0] ADR_DST    = 8'h08;
	localparam logic [7:0] ADR_DISP   = 8'h0c;
	localparam logic [7:0] ADR_FLAGS  = 8'h10;
	localparam logic [7:0] ADR_RESULT = 8'h14;
	localparam logic [7:0] ADR_STAT   = 8'h18;

	// Command register fields
	localparam int CTRL_GO       = 0;
	localparam int CTRL_OP_LO    = 1;
	localparam int CTRL_OP_HI    = 3;
	localparam int CTRL_BYTE     = 4;
	localparam int CTRL_IMM_SEL  = 5;
	localparam int CTRL_MEM_DST  = 6;
	localparam int CTRL_SRC_ZERO = 7;
	localparam int CTRL_IMM_LO   = 8;
	localparam int CTRL_IMM_HI   = 11;

	// Status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;

	// Flag register layout
	localparam int FLAG_V = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 3;

	// Reset values and zero-fill constants
	localparam logic [15:0] WORD_RST  = 16'h0000;
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;

	typedef enum logic [2:0] {
		BIT_LOAD_TO_CARRY      = 3'h0,
		LOAD_EFFECTIVE_ADDRESS = 3'h1,
		SIGNED_UPPER_LIMIT     = 3'h2,
		SIGNED_LOWER_LIMIT     = 3'h3,
		UNSIGNED_UPPER_LIMIT   = 3'h4,
		UNSIGNED_LOWER_LIMIT   = 3'h5
	} btlx_op_t;

	typedef struct packed {
		logic z;
		logic n;
		logic c;
		logic v;
	} btlx_flags_t;

	typedef struct packed {
		btlx_op_t   op;
		logic       byte_form;
		logic       imm_sel;
		logic       mem_dst;
		logic       src_zero;
		logic [3:0] four_bit_immediate;
	} btlx_cmd_t;

	typedef struct packed {
		logic        byte_rd;
		logic [15:0] addr;
	} btlx_mem_req_t;

endpackage

// file: hdl/btlx_bit_select.sv
`timescale 1ns/10ps
module btlx_bit_select (
	input  wire logic [15:0] operand,
	input  wire logic [3:0]  bit_num,
	input  wire logic        byte_form,
	output logic             carry
);

	always_comb begin
		if (byte_form && bit_num[3]) begin
			carry = 1'b0;
		end else begin
			carry = operand[bit_num];
		end
	end

endmodule // btlx_bit_select

// file: hdl/btlx_limit_unit.sv
`timescale 1ns/10ps
module btlx_limit_unit (
	input  wire btlx_pkg::btlx_op_t    op,
	input  wire logic                  byte_form,
	input  wire logic [15:0]           reg_val,
	input  wire logic [15:0]           mem_val,
	input  wire btlx_pkg::btlx_flags_t flags_in,
	output btlx_pkg::btlx_flags_t      flags_out,
	output logic [15:0]                result,
	output logic                       replaced
);

	logic [15:0] s_mem;
	logic [15:0] s_reg;
	logic [15:0] u_mem;
	logic [15:0] u_reg;
	logic        s_lt;
	logic        s_gt;
	logic        u_lt;
	logic        u_gt;
	logic        is_zero;
	logic        is_neg;

	always_comb begin
		// Byte compare on low bytes only
		s_mem = byte_form ? {{8{mem_val[7]}}, mem_val[7:0]} : mem_val;
		s_reg = byte_form ? {{8{reg_val[7]}}, reg_val[7:0]} : reg_val;
		u_mem = byte_form ? {btlx_pkg::BYTE_ZERO, mem_val[7:0]} : mem_val;
		u_reg = byte_form ? {btlx_pkg::BYTE_ZERO, reg_val[7:0]} : reg_val;
		s_lt  = $signed(s_mem) < $signed(s_reg);
		s_gt  = $signed(s_mem) > $signed(s_reg);
		u_lt  = u_mem < u_reg;
		u_gt  = u_mem > u_reg;
		case (op)
			btlx_pkg::SIGNED_UPPER_LIMIT: replaced = (flags_in.v & flags_in.n) | (~flags_in.v & s_lt);
			btlx_pkg::SIGNED_LOWER_LIMIT: replaced = (flags_in.v & ~flags_in.n) | (~flags_in.v & s_gt);
			btlx_pkg::UNSIGNED_UPPER_LIMIT: replaced = flags_in.c | u_lt;
			btlx_pkg::UNSIGNED_LOWER_LIMIT: replaced = flags_in.c | u_gt;
			default: replaced = 1'b0;
		endcase
		result = replaced ? u_mem : reg_val;
		if (byte_form && (replaced || op == btlx_pkg::UNSIGNED_UPPER_LIMIT)) begin
			result[15:8] = btlx_pkg::BYTE_ZERO;
		end
		is_zero   = byte_form ? (result[7:0] == btlx_pkg::BYTE_ZERO) : (result == btlx_pkg::WORD_RST);
		is_neg    = byte_form ? result[7] : result[15];
		flags_out = flags_in;
		case (op)
			btlx_pkg::SIGNED_UPPER_LIMIT, btlx_pkg::SIGNED_LOWER_LIMIT: begin
				if (replaced) begin
					flags_out = '{z: is_zero, n: is_neg, c: 1'b1, v: 1'b0};
				end
			end
			btlx_pkg::UNSIGNED_UPPER_LIMIT, btlx_pkg::UNSIGNED_LOWER_LIMIT: begin
				flags_out.z = is_zero;
				flags_out.n = is_neg;
				flags_out.c = 1'b0;
				flags_out.v = replaced | flags_in.v;
			end
			default: flags_out = flags_in;
		endcase
	end

endmodule // btlx_limit_unit

// file: hdl/btlx_exec.sv
`timescale 1ns/10ps
module btlx_exec (
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       mem_req,
	output btlx_pkg::btlx_mem_req_t    mem_cmd,
	input  wire logic [15:0]           mem_rdata,
	input  wire logic                  mem_ack,
	output logic                       dest_we,
	output logic [15:0]                dest_wdata,
	output logic                       flags_we,
	output btlx_pkg::btlx_flags_t      status_register
);

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ADDR = 4'b0010,
		S_READ = 4'b0100,
		S_EXEC = 4'b1000
	} btlx_state_t;

	// Bus state
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        wr_fire;
	logic [15:0] wmask;

	// Core state
	btlx_state_t             state_reg;
	btlx_state_t             state_next;
	btlx_pkg::btlx_cmd_t     cmd_reg;
	btlx_pkg::btlx_cmd_t     cmd_next;
	logic [15:0]             src_reg;
	logic [15:0]             src_next;
	logic [15:0]             dst_reg;
	logic [15:0]             dst_next;
	logic [15:0]             disp_reg;
	logic [15:0]             disp_next;
	btlx_pkg::btlx_flags_t   flags_reg;
	btlx_pkg::btlx_flags_t   flags_next;
	btlx_pkg::btlx_mem_req_t mreq_reg;
	btlx_pkg::btlx_mem_req_t mreq_next;
	logic [15:0]             mdata_reg;
	logic [15:0]             mdata_next;
	logic [15:0]             wdata_reg;
	logic [15:0]             wdata_next;
	logic                    dwe_reg;
	logic                    dwe_next;
	logic                    fwe_reg;
	logic                    fwe_next;
	logic                    done_reg;
	logic                    done_next;

	logic                    busy;
	logic                    start;
	logic                    needs_mem;
	logic                    is_limit;
	logic [15:0]             src_val;
	logic [15:0]             ea_sum;
	logic [15:0]             bit_addr;
	logic [15:0]             bit_operand;
	logic [3:0]              bit_num;
	logic                    bit_byte;
	logic                    bit_carry;
	btlx_pkg::btlx_flags_t   lim_flags;
	logic [15:0]             lim_result;
	logic                    lim_replaced;

	assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign busy     = (state_reg != S_IDLE);
	assign start    = wr_fire && (wb_adr_i == btlx_pkg::ADR_CTRL) && wb_sel_i[0] && wb_dat_i[btlx_pkg::CTRL_GO] && !busy;
	assign is_limit = (cmd_reg.op != btlx_pkg::BIT_LOAD_TO_CARRY) && (cmd_reg.op != btlx_pkg::LOAD_EFFECTIVE_ADDRESS);
	assign src_val  = cmd_reg.src_zero ? btlx_pkg::WORD_RST : src_reg;
	assign ea_sum   = disp_reg + src_val;
	assign bit_addr = disp_reg + dst_reg;
	assign bit_num  = cmd_reg.imm_sel ? cmd_reg.four_bit_immediate : src_reg[3:0];
	assign bit_byte = cmd_reg.mem_dst;
	assign bit_operand = cmd_reg.mem_dst ? {btlx_pkg::BYTE_ZERO, mdata_reg[7:0]} : dst_reg;

	btlx_bit_select u_bit_select (
		.operand   (bit_operand),
		.bit_num   (bit_num),
		.byte_form (bit_byte),
		.carry     (bit_carry)
	);

	btlx_limit_unit u_limit_unit (
		.op        (cmd_reg.op),
		.byte_form (cmd_reg.byte_form),
		.reg_val   (dst_reg),
		.mem_val   (mdata_reg),
		.flags_in  (flags_reg),
		.flags_out (lim_flags),
		.result    (lim_result),
		.replaced  (lim_replaced)
	);

	// Wishbone slave: ack one cycle after request
	always_comb begin
		ack_next   = wb_cyc_i & wb_stb_i & ~ack_reg;
		rdata_next = rdata_reg;
		if (ack_next) begin
			case (wb_adr_i)
				btlx_pkg::ADR_CTRL:   rdata_next = {16'h0000, 4'h0, cmd_reg.four_bit_immediate, cmd_reg.src_zero,
					cmd_reg.mem_dst, cmd_reg.imm_sel, cmd_reg.byte_form, cmd_reg.op, 1'b0};
				btlx_pkg::ADR_SRC:    rdata_next = {16'h0000, src_reg};
				btlx_pkg::ADR_DST:    rdata_next = {16'h0000, dst_reg};
				btlx_pkg::ADR_DISP:   rdata_next = {16'h0000, disp_reg};
				btlx_pkg::ADR_FLAGS:  rdata_next = {28'h0000000, flags_reg};
				btlx_pkg::ADR_RESULT: rdata_next = {16'h0000, wdata_reg};
				btlx_pkg::ADR_STAT:   rdata_next = {30'h00000000, done_reg, busy};
				default:              rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// Execution sequencer and register file
	always_comb begin
		state_next = state_reg;
		cmd_next   = cmd_reg;
		src_next   = src_reg;
		dst_next   = dst_reg;
		disp_next  = disp_reg;
		flags_next = flags_reg;
		mreq_next  = mreq_reg;
		mdata_next = mdata_reg;
		wdata_next = wdata_reg;
		dwe_next   = 1'b0;
		fwe_next   = 1'b0;
		done_next  = done_reg;
		needs_mem  = 1'b0;
		if (wr_fire && !busy) begin
			case (wb_adr_i)
				btlx_pkg::ADR_SRC:   src_next  = (src_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
				btlx_pkg::ADR_DST:   dst_next  = (dst_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
				btlx_pkg::ADR_DISP:  disp_next = (disp_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
				btlx_pkg::ADR_FLAGS: begin
					if (wb_sel_i[0]) begin
						flags_next = wb_dat_i[3:0];
					end
				end
				default: flags_next = flags_reg;
			endcase
		end
		if (wr_fire && (wb_adr_i == btlx_pkg::ADR_STAT) && wb_sel_i[0] && wb_dat_i[btlx_pkg::STAT_DONE]) begin
			done_next = 1'b0;
		end
		case (state_reg)
			S_IDLE: begin
				if (start) begin
					cmd_next = '{op: btlx_pkg::btlx_op_t'(wb_dat_i[btlx_pkg::CTRL_OP_HI:btlx_pkg::CTRL_OP_LO]),
						byte_form: wb_dat_i[btlx_pkg::CTRL_BYTE], imm_sel: wb_dat_i[btlx_pkg::CTRL_IMM_SEL],
						mem_dst: wb_dat_i[btlx_pkg::CTRL_MEM_DST], src_zero: wb_dat_i[btlx_pkg::CTRL_SRC_ZERO],
						four_bit_immediate: wb_dat_i[btlx_pkg::CTRL_IMM_HI:btlx_pkg::CTRL_IMM_LO]};
					state_next = S_ADDR;
				end
			end
			S_ADDR: begin
				needs_mem = is_limit || ((cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY) && cmd_reg.mem_dst);
				mreq_next.addr    = (cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY) ? bit_addr : ea_sum;
				mreq_next.byte_rd = is_limit ? cmd_reg.byte_form : 1'b1;
				state_next = needs_mem ? S_READ : S_EXEC;
			end
			S_READ: begin
				if (mem_ack) begin
					mdata_next = mreq_reg.byte_rd ? {btlx_pkg::BYTE_ZERO, mem_rdata[7:0]} : mem_rdata;
					state_next = S_EXEC;
				end
			end
			S_EXEC: begin
				fwe_next   = 1'b1;
				done_next  = 1'b1;
				state_next = S_IDLE;
				case (cmd_reg.op)
					btlx_pkg::BIT_LOAD_TO_CARRY: flags_next.c = bit_carry;
					btlx_pkg::LOAD_EFFECTIVE_ADDRESS: begin
						wdata_next = ea_sum;
						dwe_next   = 1'b1;
					end
					default: begin
						wdata_next = lim_result;
						flags_next = lim_flags;
						dwe_next   = 1'b1;
					end
				endcase
				if (cmd_reg.op != btlx_pkg::BIT_LOAD_TO_CARRY) begin
					dst_next = (cmd_reg.op == btlx_pkg::LOAD_EFFECTIVE_ADDRESS) ? ea_sum : lim_result;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= S_IDLE;
			cmd_reg   <= '0;
			src_reg   <= btlx_pkg::WORD_RST;
			dst_reg   <= btlx_pkg::WORD_RST;
			disp_reg  <= btlx_pkg::WORD_RST;
			flags_reg <= btlx_pkg::FLAGS_RST;
			mreq_reg  <= '0;
			mdata_reg <= btlx_pkg::WORD_RST;
			wdata_reg <= btlx_pkg::WORD_RST;
			dwe_reg   <= 1'b0;
			fwe_reg   <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg   <= cmd_next;
			src_reg   <= src_next;
			dst_reg   <= dst_next;
			disp_reg  <= disp_next;
			flags_reg <= flags_next;
			mreq_reg  <= mreq_next;
			mdata_reg <= mdata_next;
			wdata_reg <= wdata_next;
			dwe_reg   <= dwe_next;
			fwe_reg   <= fwe_next;
			done_reg  <= done_next;
		end
	end

	assign mem_req         = (state_reg == S_READ);
	assign mem_cmd         = mreq_reg;
	assign dest_we         = dwe_reg;
	assign dest_wdata      = wdata_reg;
	assign flags_we        = fwe_reg;
	assign status_register = flags_reg;

	// Checks
	logic in_exec;
	assign in_exec = (state_reg == S_EXEC);

	AST_BITLOAD_KEEPS: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY |=> flags_we && !dest_we
		&& {flags_reg.z, flags_reg.n, flags_reg.v} == $past({flags_reg.z, flags_reg.n, flags_reg.v}))
		else $error("bit load changed other flags");
	AST_BITLOAD_WORD: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY && !cmd_reg.mem_dst
		|=> flags_reg.c == $past(dst_reg[bit_num]))
		else $error("bit load carry wrong");
	AST_BYTE_READ: assert property (@(posedge clock) disable iff (srst)
		mem_req && cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY |-> mem_cmd.byte_rd)
		else $error("bit load read not byte wide");
	AST_HIGH_BIT_ZERO: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY && cmd_reg.mem_dst && bit_num[3] |=> !flags_reg.c)
		else $error("byte bit above 7 set carry");
	AST_EA_SUM: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::LOAD_EFFECTIVE_ADDRESS
		|=> dest_we && dest_wdata == $past(disp_reg) + $past(src_val) && status_register == $past(flags_reg))
		else $error("effective address wrong");
	AST_EA_ZERO_SRC: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::LOAD_EFFECTIVE_ADDRESS && cmd_reg.src_zero |=> dest_wdata == $past(disp_reg))
		else $error("zero source not honoured");
	AST_SIGNED_KEEP: assert property (@(posedge clock) disable iff (srst)
		in_exec && (cmd_reg.op == btlx_pkg::SIGNED_UPPER_LIMIT || cmd_reg.op == btlx_pkg::SIGNED_LOWER_LIMIT)
		&& !lim_replaced |=> status_register == $past(flags_reg) && dest_wdata == $past(dst_reg))
		else $error("signed limit changed state without replace");
	AST_UNSIGNED_CARRY: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op inside {btlx_pkg::UNSIGNED_UPPER_LIMIT, btlx_pkg::UNSIGNED_LOWER_LIMIT}
		|=> !status_register.c && (status_register.v == ($past(lim_replaced) | $past(flags_reg.v))))
		else $error("unsigned limit flags wrong");
	AST_UUL_UPPER: assert property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::UNSIGNED_UPPER_LIMIT && cmd_reg.byte_form |=> dest_wdata[15:8] == 8'h00)
		else $error("byte upper limit kept upper byte");
	AST_COMMIT_TOGETHER: assert property (@(posedge clock) disable iff (srst)
		dest_we |-> flags_we && $past(state_reg, 1) == S_EXEC && $past(state_reg, 2) != S_IDLE)
		else $error("register and flags not committed together");
	AST_ADDR_WRAP: assert property (@(posedge clock) disable iff (srst)
		state_reg == S_ADDR && is_limit ##1 state_reg == S_READ |-> mem_cmd.addr == $past(disp_reg) + $past(src_val))
		else $error("operand address wrong");
	AST_BITLOAD_ADDR: assert property (@(posedge clock) disable iff (srst)
		state_reg == S_ADDR && cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY && cmd_reg.mem_dst ##1 state_reg == S_READ
		|-> mem_cmd.addr == $past(disp_reg) + $past(dst_reg))
		else $error("bit load address wrong");

	COV_BITLOAD_MEM: cover property (@(posedge clock) disable iff (srst)
		in_exec && cmd_reg.op == btlx_pkg::BIT_LOAD_TO_CARRY && cmd_reg.mem_dst);
	COV_EA: cover property (@(posedge clock) disable iff (srst) in_exec && cmd_reg.op == btlx_pkg::LOAD_EFFECTIVE_ADDRESS);
	COV_LIMIT_REPLACE: cover property (@(posedge clock) disable iff (srst) in_exec && is_limit && lim_replaced);
	COV_LIMIT_KEEP: cover property (@(posedge clock) disable iff (srst) in_exec && is_limit && !lim_replaced);

endmodule // btlx_exec

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
	logic                     clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, mem_ack;
	logic [7:0]               wb_adr_i;
	logic [3:0]               wb_sel_i;
	logic [31:0]              wb_dat_i, wb_dat_o, rd;
	logic                     wb_ack_o, mem_req, dest_we, flags_we;
	logic [15:0]              mem_rdata, dest_wdata, mem_val, exp_addr, got_w;
	btlx_pkg::btlx_mem_req_t  mem_cmd;
	btlx_pkg::btlx_flags_t    status_register, got_f;
	logic                     exp_byte, chk_addr, got_d, got_fw;
	logic [31:0]              r1, r2, r3;
	logic [2:0]               op;
	integer                   seed, mismatches, n_checks, n_commit, mem_cnt, mdly, i;

	btlx_exec dut_u (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dest_we(dest_we),
		.dest_wdata(dest_wdata), .flags_we(flags_we), .status_register(status_register));

	always #12.5 clock = ~clock;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks = n_checks + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
		int k;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= dw;
		wb_sel_i <= 4'hf;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		chk(k < 50, 1);
		dr = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wb_wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] x;
		wb_cycle(1'b1, a, {16'($random(seed)), d}, x);
	endtask

	// Expected {z,n,c,v,dest}
	function automatic logic [19:0] model(input logic [2:0] o, input logic bf, ims, md, sz, input logic [3:0] imm,
		input logic [15:0] s, d, dp, input logic [3:0] f, input logic [15:0] m);
		logic        z, n, c, v, rep;
		logic [15:0] r, mv, dv;
		logic [3:0]  b;
		{z, n, c, v} = f;
		r = d;
		b = ims ? imm : s[3:0];
		mv = bf ? {8'h00, m[7:0]} : m;
		dv = bf ? {8'h00, d[7:0]} : d;
		rep = 1'b0;
		case (o)
			3'h0: c = md ? (b < 4'h8 && m[b[2:0]]) : d[b];
			3'h1: r = (sz ? 16'h0000 : s) + dp;
			3'h2: rep = (v && n) || (!v && (bf ? $signed(m[7:0]) < $signed(d[7:0]) : $signed(m) < $signed(d)));
			3'h3: rep = (v && !n) || (!v && (bf ? $signed(m[7:0]) > $signed(d[7:0]) : $signed(m) > $signed(d)));
			3'h4: rep = c || mv < dv;
			3'h5: rep = c || mv > dv;
			default: ;
		endcase
		if (rep) r = mv;
		if (o == 3'h4 && bf) r[15:8] = 8'h00;
		if (o >= 3'h2 && (rep || o >= 3'h4)) begin
			z = (bf ? {8'h00, r[7:0]} : r) == 16'h0000;
			n = bf ? r[7] : r[15];
		end
		if (o >= 3'h2 && o <= 3'h3 && rep) begin
			c = 1'b1;
			v = 1'b0;
		end
		if (o >= 3'h4) begin
			v = v | rep;
			c = 1'b0;
		end
		return {z, n, c, v, r};
	endfunction

	task automatic run_op(input logic [2:0] o, input logic bf, ims, md, sz, input logic [3:0] imm,
		input logic [15:0] s, d, dp, input logic [3:0] f, input logic [15:0] m);
		logic [19:0] e;
		logic        usem;
		int          n0, m0, k;
		e = model(o, bf, ims, md, sz, imm, s, d, dp, f, m);
		usem = (o == 3'h0) ? md : (o >= 3'h2);
		wb_wr(btlx_pkg::ADR_STAT, 16'h0002);
		wb_wr(btlx_pkg::ADR_SRC, s);
		wb_wr(btlx_pkg::ADR_DST, d);
		wb_wr(btlx_pkg::ADR_DISP, dp);
		wb_wr(btlx_pkg::ADR_FLAGS, {12'h000, f});
		mem_val = m;
		exp_byte = (o == 3'h0) ? 1'b1 : bf;
		chk_addr = 1'b1;
		exp_addr = (o == 3'h0) ? dp + d : dp + s;
		n0 = n_commit;
		m0 = mem_cnt;
		wb_wr(btlx_pkg::ADR_CTRL, {4'h0, imm, sz, md, ims, bf, o, 1'b1});
		if (usem) wb_wr(btlx_pkg::ADR_DST, ~d);
		k = 0;
		while (n_commit == n0 && k < 200) begin
			@(posedge clock);
			k++;
		end
		chk(got_f, e[19:16]);
		if (o != 3'h0) chk(got_w, e[15:0]);
		chk({got_d, got_fw}, o == 3'h0 ? 2'b01 : 2'b11);
		wb_cycle(1'b0, btlx_pkg::ADR_DST, 32'h0, rd);
		chk(rd, {16'h0000, e[15:0]});
		wb_cycle(1'b0, btlx_pkg::ADR_RESULT, 32'h0, rd);
		if (o != 3'h0) chk(rd, {16'h0000, e[15:0]});
		wb_cycle(1'b0, btlx_pkg::ADR_STAT, 32'h0, rd);
		chk(rd[1:0], 2'b10);
		chk(mem_cnt - m0, usem);
		chk(n_commit - n0, 1);
	endtask

	// Same-clock memory, random wait, junk data outside the answer
	always @(posedge clock) begin
		if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
			if (mdly == 0) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_val;
				mem_cnt <= mem_cnt + 1;
				mdly <= $random(seed) & 3;
				chk(mem_cmd.byte_rd, exp_byte);
				if (chk_addr) chk(mem_cmd.addr, exp_addr);
			end else begin
				mdly <= mdly - 1;
			end
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'($random(seed));
		end
	end

	always @(posedge clock) begin
		if (dest_we === 1'b1 || flags_we === 1'b1) begin
			got_d <= dest_we;
			got_fw <= flags_we;
			got_w <= dest_wdata;
			got_f <= status_register;
			n_commit <= n_commit + 1;
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		mismatches = mismatches + 1;
		stop_test;
	end

	initial begin
		{clock, wb_cyc_i, wb_stb_i, wb_we_i, mem_ack, got_d, got_fw} = 7'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i, mem_rdata, mem_val, exp_addr, got_w} = 0;
		{exp_byte, chk_addr, got_f} = 0;
		seed = 32'hcaa3bea0;
		{mismatches, n_checks, n_commit, mem_cnt, mdly} = 0;
		srst = 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		chk(status_register, 4'h0);
		wb_cycle(1'b0, btlx_pkg::ADR_DST, 32'h0, rd);
		chk(rd, 32'h0);
		wb_cycle(1'b0, btlx_pkg::ADR_FLAGS, 32'h0, rd);
		chk(rd, 32'h0);
		wb_cycle(1'b0, btlx_pkg::ADR_STAT, 32'h0, rd);
		chk(rd, 32'h0);
		wb_wr(8'h40, 16'hbeef);
		wb_cycle(1'b0, 8'h40, 32'h0, rd);
		chk(rd, 32'h0);
		run_op(3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 4'hc, 16'h0000, 16'h0000, 16'h0010, 4'h2, 16'hffff);
		run_op(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'hfff5, 16'h0020, 16'h0000, 4'h0, 16'h0000);
		run_op(3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 16'h1234, 16'h5555, 16'hffff, 4'hf, 16'h0000);
		run_op(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'hffff, 16'h0000, 16'h0002, 4'h5, 16'h0000);
		run_op(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0001, 16'h8000, 16'hffff, 4'h0, 16'h7fff);
		run_op(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0100, 16'h12f0, 16'h0004, 4'h1, 16'h3480);
		run_op(3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0002, 16'hab10, 16'h0030, 4'h0, 16'h0020);
		run_op(3'h5, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0003, 16'h0005, 16'h0040, 4'h2, 16'h0001);
		wb_cycle(1'b0, btlx_pkg::ADR_CTRL, 32'h0, rd);
		chk(rd[0], 1'b0);
		for (i = 0; i < 80; i++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			r3 = $random(seed);
			op = 3'($unsigned(r1[15:8]) % 6);
			run_op(op, r1[0], r1[1], r1[2], r1[3] && op == 3'h1, r1[7:4], r2[15:0], r2[31:16], r3[15:0],
				r3[19:16], r1[31:16]);
		end
		stop_test;
	end
endmodule // tb
